// File: shared/adc_port_pkg.sv
package adc_port_pkg;
    // Width of one converted sample word.
    localparam int SAMPLE_BITS = 10;
    // Sample clocks from the sampling edge to the word on the pins.
    localparam int PIPELINE_LATENCY = 6;
    // Depth of the word buffer in the data path.
    localparam int BUFFER_DEPTH = 16;
    // Aperture delay in picoseconds and in mclk cycles (at least one cycle).
    localparam int APERTURE_DELAY_PS = 1000;
    localparam int MCLK_PERIOD_PS = 4000;
    localparam int APERTURE_CYCLES_RAW = (APERTURE_DELAY_PS + MCLK_PERIOD_PS - 1) / MCLK_PERIOD_PS;
    localparam int APERTURE_CYCLES = (APERTURE_CYCLES_RAW < 1) ? 1 : APERTURE_CYCLES_RAW;
    // Register offsets on the plain register port.
    localparam logic [3:0] REG_CONTROL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_LAST_CODE = 4'h8;
    // Control register field positions and reset value.
    localparam int CTRL_OUT_ENABLE_BIT = 0;
    localparam int CTRL_REF_SELECT_BIT = 1;
    localparam int CTRL_BIAS_LO_BIT = 2;
    localparam int CTRL_BIAS_HI_BIT = 3;
    localparam logic [3:0] CONTROL_RESET = 4'hD;
    // Bias level encodings, high select bit first.
    typedef enum logic [1:0] {
        BIAS_SLEEP = 2'b00,
        BIAS_REDUCED = 2'b01,
        BIAS_INCREASED = 2'b10,
        BIAS_TYPICAL = 2'b11
    } bias_level_t;
    // Sampler state machine.
    typedef enum logic [1:0] {
        SMP_IDLE = 2'b00,
        SMP_APERTURE = 2'b01,
        SMP_CAPTURE = 2'b10
    } sampler_state_t;
endpackage

// File: hdl/sample_fifo.sv
`timescale 1ns/10ps
module sample_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 16
) (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst_n,
    // Filling side.
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // Draining side.
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [AW:0] count;
    logic doWrite;
    logic doRead;

    ////////////////////////////////////////////////////////////////////////////
    // Handshakes on each side.
    assign doWrite = inValid && inReady;
    assign doRead = outValid && outReady;
    assign inReady = (count != (AW+1)'(DEPTH));
    assign outValid = (count != '0);
    assign outData = mem[rdPtr];

    // Storage write.
    always_ff @(posedge mclk) begin
        if (doWrite) begin
            mem[wrPtr] <= inData;
        end
    end

    // Pointers and fill count.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end else begin
            if (doWrite) begin
                wrPtr <= (wrPtr == AW'(DEPTH - 1)) ? '0 : wrPtr + AW'(1);
            end
            if (doRead) begin
                rdPtr <= (rdPtr == AW'(DEPTH - 1)) ? '0 : rdPtr + AW'(1);
            end
            count <= count + (AW+1)'(doWrite) - (AW+1)'(doRead);
        end
    end

    // The buffer never overflows or underflows.
    a_fifo_bounds: assert property (@(posedge mclk) disable iff (!rst_n)
        count <= (AW+1)'(DEPTH)) else $error("fifo count above depth");
endmodule // sample_fifo

// File: hdl/adc_digital_port.sv
// Local design decisions: the placing of the registers and strobed register access.
`timescale 1ns/10ps
// Functional notes
// - Ref select one: external reference, internal off.
// - Ref select zero: on-chip reference sets range.
// - Sample on falling clock, after aperture delay.
// - Offset binary: negative full scale all zeros.
// - Word appears six sample clocks after sampling.
// - Output enable high drives, low floats.
// - Bias: 00 sleep, 01 -12.5%, 10 +12.5%, 11 typical.
// - Ten bits, MSB on highest pin.
module adc_digital_port
    import adc_port_pkg::*;
#(
    parameter int WIDTH = SAMPLE_BITS,
    parameter int LATENCY = PIPELINE_LATENCY,
    parameter int DEPTH = BUFFER_DEPTH
) (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst_n,
    // Sample clock from the capture logic, synchronous to mclk.
    input wire logic sampleClock,
    // Signed quantiser result, two's complement, taken at the capture moment.
    input wire logic [WIDTH-1:0] quantizerCode,
    // Register port.
    input wire logic [3:0] regAddr,
    input wire logic [31:0] regWriteData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [31:0] regReadData,
    // Data pins.
    output logic [WIDTH-1:0] sample_code_out,
    output logic sampleCodeOutEnable,
    // Analog control outputs and the pin word strobe.
    output logic internalRefEnable,
    output logic externalRefSelected,
    output logic [1:0] biasLevel,
    output logic sleepMode,
    output logic sampleStrobe
);
    logic [3:0] control;
    logic reference_source_select;
    logic bias_level_select_lo;
    logic bias_level_select_hi;
    logic outEnable;
    logic clockPrev;
    logic fallEdge;
    logic riseEdge;
    sampler_state_t smpState;
    logic [3:0] apertureCount;
    logic captureNow;
    logic [WIDTH-1:0] offsetCode;
    logic [WIDTH-1:0] pipe [LATENCY];
    logic [LATENCY-1:0] pipeValid;
    logic fifoInReady;
    logic fifoOutValid;
    logic [WIDTH-1:0] fifoOutData;
    logic [WIDTH-1:0] lastCode;
    logic overrun;
    logic drain;
    logic next_sleep;

    ////////////////////////////////////////////////////////////////////////////
    // Control register fields.
    assign outEnable = control[CTRL_OUT_ENABLE_BIT];
    assign reference_source_select = control[CTRL_REF_SELECT_BIT];
    assign bias_level_select_lo = control[CTRL_BIAS_LO_BIT];
    assign bias_level_select_hi = control[CTRL_BIAS_HI_BIT];

    // Register writes.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            control <= CONTROL_RESET;
        end else if (regWrite && regAddr == REG_CONTROL) begin
            control <= regWriteData[3:0];
        end
    end

    // Register reads; data stand only in the cycle after the strobe.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            regReadData <= 32'h0000_0000;
        end else if (regRead) begin
            case (regAddr)
                REG_CONTROL: regReadData <= {28'h000_0000, control};
                REG_STATUS: regReadData <= {28'h000_0000, sleepMode, overrun, fifoOutValid, !fifoInReady};
                REG_LAST_CODE: regReadData <= {{(32-WIDTH){1'b0}}, lastCode};
                default: regReadData <= 32'h0000_0000;
            endcase
        end else begin
            regReadData <= 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reference and bias decode, registered onto the pins.
    assign next_sleep = ({bias_level_select_hi, bias_level_select_lo} == BIAS_SLEEP);
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            internalRefEnable <= 1'b1;
            externalRefSelected <= 1'b0;
            biasLevel <= BIAS_TYPICAL;
            sleepMode <= 1'b0;
        end else begin
            externalRefSelected <= reference_source_select;
            internalRefEnable <= !reference_source_select;
            biasLevel <= {bias_level_select_hi, bias_level_select_lo};
            sleepMode <= next_sleep;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sample clock edge detection.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            clockPrev <= 1'b1; // Matches the idle-high sample clock, so no false edge follows reset.
        end else begin
            clockPrev <= sampleClock;
        end
    end
    assign fallEdge = clockPrev && !sampleClock;
    assign riseEdge = !clockPrev && sampleClock;

    // Aperture delay after each falling edge, then one capture. Sleep stops sampling.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            smpState <= SMP_IDLE;
            apertureCount <= 4'h0;
        end else begin
            case (smpState)
                SMP_IDLE: begin
                    if (fallEdge && !sleepMode) begin
                        smpState <= (APERTURE_CYCLES > 1) ? SMP_APERTURE : SMP_CAPTURE;
                        apertureCount <= 4'(APERTURE_CYCLES - 1);
                    end
                end
                SMP_APERTURE: begin
                    apertureCount <= apertureCount - 4'h1;
                    if (apertureCount == 4'h1) begin
                        smpState <= SMP_CAPTURE;
                    end
                end
                SMP_CAPTURE: begin
                    smpState <= SMP_IDLE;
                end
                default: smpState <= SMP_IDLE;
            endcase
        end
    end
    assign captureNow = (smpState == SMP_CAPTURE);

    // Offset binary: flip the sign bit of the two's complement result.
    assign offsetCode = {~quantizerCode[WIDTH-1], quantizerCode[WIDTH-2:0]};

    ////////////////////////////////////////////////////////////////////////////
    // Pipeline advanced on every falling sample edge; a word leaves after LATENCY edges.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pipeValid <= '0;
            for (int i = 0; i < LATENCY; i++) begin
                pipe[i] <= '0;
            end
        end else begin
            if (captureNow) begin
                pipe[0] <= offsetCode;
                pipeValid[0] <= 1'b1;
            end
            if (fallEdge) begin
                for (int i = 1; i < LATENCY; i++) begin
                    pipe[i] <= pipe[i-1];
                    pipeValid[i] <= pipeValid[i-1];
                end
                if (!captureNow) begin
                    pipeValid[0] <= 1'b0;
                end
            end
        end
    end

    // Words leaving the pipeline are buffered; overrun is flagged sticky when full.
    sample_fifo #(
        .WIDTH(WIDTH),
        .DEPTH(DEPTH)
    ) sample_fifo_i (
        .mclk(mclk),
        .rst_n(rst_n),
        .inValid(fallEdge && pipeValid[LATENCY-1]),
        .inReady(fifoInReady),
        .inData(pipe[LATENCY-1]),
        .outValid(fifoOutValid),
        .outReady(drain),
        .outData(fifoOutData)
    );

    // The pin stage drains one word per rising sample edge.
    assign drain = riseEdge;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            overrun <= 1'b0;
        end else if (fallEdge && pipeValid[LATENCY-1] && !fifoInReady) begin
            overrun <= 1'b1;
        end else if (regWrite && regAddr == REG_STATUS && regWriteData[2]) begin
            overrun <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Data pins, MSB on the highest bit, driven only while enabled.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sample_code_out <= '0;
            lastCode <= '0;
            sampleStrobe <= 1'b0;
            sampleCodeOutEnable <= 1'b0;
        end else begin
            sampleCodeOutEnable <= outEnable;
            sampleStrobe <= drain && fifoOutValid;
            if (drain && fifoOutValid) begin
                sample_code_out <= fifoOutData;
                lastCode <= fifoOutData;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    a_ref_select: assert property (@(posedge mclk) disable iff (!rst_n)
        ##1 internalRefEnable == !$past(reference_source_select)) else $error("ref select");
    a_ref_internal: assert property (@(posedge mclk) disable iff (!rst_n)
        !reference_source_select |=> internalRefEnable && !externalRefSelected) else $error("internal ref");
    a_capture_after_fall: assert property (@(posedge mclk) disable iff (!rst_n)
        captureNow |-> $past(fallEdge, APERTURE_CYCLES)) else $error("capture not after fall");
    a_offset_binary: assert property (@(posedge mclk) disable iff (!rst_n)
        offsetCode[WIDTH-1] != quantizerCode[WIDTH-1]) else $error("offset code");
    a_pipe_shift: assert property (@(posedge mclk) disable iff (!rst_n)
        fallEdge |=> pipe[LATENCY-1] == $past(pipe[LATENCY-2])) else $error("pipeline shift");
    a_oe_follow: assert property (@(posedge mclk) disable iff (!rst_n)
        $changed(outEnable) |=> sampleCodeOutEnable == $past(outEnable)) else $error("output enable");
    a_bias_sleep: assert property (@(posedge mclk) disable iff (!rst_n)
        sleepMode == (biasLevel == BIAS_SLEEP)) else $error("bias decode");
    a_pin_word: assert property (@(posedge mclk) disable iff (!rst_n)
        sampleStrobe |-> sample_code_out == $past(fifoOutData) && lastCode == sample_code_out)
        else $error("pin word");
    a_sleep_no_sample: assert property (@(posedge mclk) disable iff (!rst_n)
        sleepMode && smpState == SMP_IDLE |=> smpState != SMP_CAPTURE) else $error("sampling in sleep");

    ////////////////////////////////////////////////////////////////////////////
    // Further checks on the sampler, the pipeline and the register port.

    // Selecting the external reference powers the internal one down on the next edge.
    a_reference_source_select_on: assert property (@(posedge mclk) disable iff (!rst_n)
        reference_source_select |=> externalRefSelected && !internalRefEnable)
        else $error("external ref");

    // A capture lasts exactly one cycle, so each falling edge yields at most one sample.
    a_capture_single: assert property (@(posedge mclk) disable iff (!rst_n)
        captureNow |=> !captureNow) else $error("capture longer than one cycle");

    // The first pipeline stage takes the offset binary word of the capture cycle.
    a_pipe_entry: assert property (@(posedge mclk) disable iff (!rst_n)
        captureNow |=> pipe[0] == $past(offsetCode) && pipeValid[0]) else $error("pipe entry");

    // Pin words are single-cycle strobes, since drains follow rising edges only.
    a_strobe_pulse: assert property (@(posedge mclk) disable iff (!rst_n)
        sampleStrobe |=> !sampleStrobe) else $error("strobe longer than one cycle");

    // The pins only change together with a strobe.
    a_pins_steady: assert property (@(posedge mclk) disable iff (!rst_n)
        !sampleStrobe |-> $stable(sample_code_out)) else $error("pins moved without strobe");

    // Read data stand for one cycle after a read and are zero otherwise.
    a_read_idle: assert property (@(posedge mclk) disable iff (!rst_n)
        !regRead |=> regReadData == 32'h0000_0000) else $error("read data outside window");

    // The overrun flag stays set until software clears it.
    a_overrun_hold: assert property (@(posedge mclk) disable iff (!rst_n)
        overrun && !(regWrite && regAddr == REG_STATUS && regWriteData[2]) |=> overrun)
        else $error("overrun dropped");

    // Sleep reaches the pin outputs one edge after the bias fields select it.
    a_sleep_decode: assert property (@(posedge mclk) disable iff (!rst_n)
        next_sleep |=> sleepMode && biasLevel == BIAS_SLEEP) else $error("sleep decode");

    c_capture: cover property (@(posedge mclk) disable iff (!rst_n) captureNow);
    c_output_word: cover property (@(posedge mclk) disable iff (!rst_n) sampleStrobe);
    c_overrun: cover property (@(posedge mclk) disable iff (!rst_n) $rose(overrun));
    c_external_ref: cover property (@(posedge mclk) disable iff (!rst_n) externalRefSelected);
    c_sleep: cover property (@(posedge mclk) disable iff (!rst_n) sleepMode);
endmodule // adc_digital_port

// File: dv/capture_model.sv
`timescale 1ns/10ps
module capture_model #(
    parameter int HALF = 4
) (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst_n,
    // Control from the bench and words from the converter.
    input wire logic run,
    input wire logic sampleStrobe,
    input wire logic [9:0] pinWord,
    // Stimulus towards the converter, and the fall count and last word for the bench.
    output logic sampleClock,
    output logic [9:0] quantizerCode,
    output int fallCount,
    output logic [9:0] lastWord
);
    int phase;

    // Input value applied at fall number i, with both full-scale extremes.
    function automatic logic [9:0] codeAt(input int i);
        if (i == 7) return 10'h200;
        if (i == 8) return 10'h1FF;
        return 10'((i * 37) + 5);
    endfunction

    // Sample clock stands high outside runs; the input moves away after the aperture cycle.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sampleClock <= 1'b1;
            phase <= 0;
            fallCount <= 0;
            quantizerCode <= 10'h155;
        end else if (run || !sampleClock) begin
            phase <= phase + 1;
            if (phase == 1 && !sampleClock) begin
                quantizerCode <= ~quantizerCode;
            end
            if (phase == HALF - 1) begin
                phase <= 0;
                sampleClock <= !sampleClock;
                if (sampleClock) begin
                    quantizerCode <= codeAt(fallCount);
                    fallCount <= fallCount + 1;
                end
            end
        end
    end

    // Latches words once the pipeline has flushed its start-up words.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            lastWord <= 10'h000;
        end else if (sampleStrobe && fallCount > 7) begin
            lastWord <= pinWord;
        end
    end
endmodule // capture_model

// File: dv/adc_digital_port_tb_top.sv
`timescale 1ns/10ps
module adc_digital_port_tb_top;
    import adc_port_pkg::*;
    logic mclk, rst_n, run, regWrite, regRead;
    logic [3:0] regAddr;
    logic [31:0] regWriteData, regReadData, rd;
    logic [9:0] sample_code_out, quantizerCode, lastWord, lastExp;
    logic sampleCodeOutEnable, internalRefEnable, externalRefSelected, sleepMode, sampleStrobe, sampleClock;
    logic [1:0] biasLevel;
    int fallCount, badCount, testsRun, seen;
    wire [9:0] pinBus;

    // The data pins as the far side sees them.
    assign pinBus = sampleCodeOutEnable ? sample_code_out : 10'hZZZ;

    adc_digital_port adc_digital_port_i (.mclk(mclk), .rst_n(rst_n), .sampleClock(sampleClock),
        .quantizerCode(quantizerCode), .regAddr(regAddr), .regWriteData(regWriteData), .regWrite(regWrite),
        .regRead(regRead), .regReadData(regReadData), .sample_code_out(sample_code_out),
        .sampleCodeOutEnable(sampleCodeOutEnable), .internalRefEnable(internalRefEnable),
        .externalRefSelected(externalRefSelected), .biasLevel(biasLevel), .sleepMode(sleepMode),
        .sampleStrobe(sampleStrobe));
    capture_model capture_model_i (.mclk(mclk), .rst_n(rst_n), .run(run), .sampleStrobe(sampleStrobe),
        .pinWord(pinBus), .sampleClock(sampleClock), .quantizerCode(quantizerCode), .fallCount(fallCount),
        .lastWord(lastWord));

    ////////////////////////////////////////////////////////////////////////////////
    // Compares, bus cycles and the closing report.
    task automatic check_val(input logic [31:0] got, input logic [31:0] exp, input string what);
        testsRun++;
        if (got !== exp) begin
            badCount++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic check_pins(input logic [9:0] got, input logic [9:0] exp);
        testsRun++;
        if (got !== exp) begin
            badCount++;
            $display("unexpected at %0t: pin word %h expected %h", $time, got, exp);
        end
    endtask
    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        regAddr <= a;
        regWriteData <= d;
        regWrite <= 1'b1;
        @(posedge mclk);
        regWrite <= 1'b0;
        repeat (2) @(posedge mclk);
        #1;
    endtask
    task automatic reg_read(input logic [3:0] a);
        @(posedge mclk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge mclk);
        regRead <= 1'b0;
        #1 rd = regReadData;
    endtask
    task automatic tallyAndFinish;
        if (badCount == 0 && testsRun > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Scenarios.
    task automatic reset_check;
        reg_read(REG_CONTROL);
        check_val(rd, {28'h0, CONTROL_RESET}, "control reset");
        check_val({29'h0, sampleCodeOutEnable, internalRefEnable, externalRefSelected}, 32'h6, "reset pins");
        check_val({30'h0, biasLevel}, 32'h3, "reset bias");
        reg_read(4'hC);
        check_val(rd, 32'h0, "unmapped read");
    endtask
    task automatic ref_check;
        for (int r = 1; r >= 0; r--) begin
            reg_write(REG_CONTROL, {28'h0, 2'b11, r[0], 1'b1});
            check_val({31'h0, externalRefSelected}, 32'(r), "external ref");
            check_val({31'h0, internalRefEnable}, 32'(1 - r), "internal ref");
        end
    endtask
    task automatic bias_check;
        for (int b = 0; b < 4; b++) begin
            reg_write(REG_CONTROL, {28'h0, b[1:0], 2'b01});
            check_val({30'h0, biasLevel}, 32'(b), "bias level");
            check_val({31'h0, sleepMode}, 32'(b == 0), "sleep");
            reg_read(REG_STATUS);
            check_val({31'h0, rd[3]}, 32'(b == 0), "status sleep");
        end
    endtask
    task automatic watch(input int cycles, input logic floating);
        seen = 0;
        repeat (cycles) begin
            @(posedge mclk);
            #1;
            if (sampleStrobe === 1'b1 && fallCount >= 7) begin
                seen++;
                if (floating) check_pins(pinBus, 10'hZZZ);
                else check_pins(pinBus, capture_model_i.codeAt(fallCount - 7) ^ 10'h200);
            end
        end
    endtask
    task automatic stream_check;
        run <= 1'b1;
        watch(400, 1'b0);
        check_val(32'(seen >= 40), 32'h1, "too few words");
        // Align to a fresh strobe so neither the latch nor the register moves before the compare.
        seen = 0;
        while (seen < 16 && sampleStrobe !== 1'b1) begin
            @(posedge mclk);
            #1;
            seen++;
        end
        check_val(32'(seen < 16), 32'h1, "no word before register read");
        lastExp = capture_model_i.codeAt(fallCount - 7) ^ 10'h200;
        reg_read(REG_LAST_CODE);
        check_val(rd, {22'h0, lastExp}, "last code register");
        check_val({22'h0, lastWord}, {22'h0, lastExp}, "captured");
    endtask
    task automatic float_check;
        reg_write(REG_CONTROL, 32'hC);
        watch(80, 1'b1);
        check_val(32'(seen >= 5), 32'h1, "no words while floating");
        reg_write(REG_CONTROL, 32'hD);
        watch(80, 1'b0);
    endtask
    task automatic sleep_check;
        reg_write(REG_CONTROL, 32'h1);
        repeat (80) @(posedge mclk);
        seen = 0;
        repeat (64) begin
            @(posedge mclk);
            #1;
            if (sampleStrobe !== 1'b0) seen++;
        end
        check_val(32'(seen), 32'h0, "words during sleep");
        run <= 1'b0;
    endtask

    // Clock.
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    // Main sequence.
    initial begin
        {rst_n, run, regWrite, regRead, regAddr, regWriteData, badCount, testsRun} = '0;
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        reset_check();
        ref_check();
        bias_check();
        stream_check();
        float_check();
        sleep_check();
        tallyAndFinish();
    end
endmodule // adc_digital_port_tb_top
